// File: compact_timer_control.sv
// Purpose: Compact 10-bit up-counting timer with compare A, 3-bit period compare and PWM
// Assumes: All inputs synchronous to i_clk_sys; high and sub clocks arrive as one-cycle ticks
// Notes: Avalon-MM slave, each access answered with exactly one low-waitrequest cycle
//
// Functional notes
// (RL1) Pause freezes counter at its value, module stays powered; clearing resumes.
// (RL2) Clock select: sys/4, sys, high/16, high/64, sub, reserved, pin rise, pin fall.
// (RL3) Reserved clock code gives no count clock; counter does not advance.
// (RL4) Counter-on rising clears counter; falling stops and holds the value.
// (RL5) Compare mode: counter-on rising returns the output to the initial level.
// (RL6) Period value compares counter bits 9..7; steps of 128; zero means 1024.
// (RL7) Clear source zero: clear on period match, or overflow when period is zero.
// (RL8) Clear source one: clear when counter matches the 10-bit compare A value.
// (RL9) Mode field: compare output, undefined, PWM, timer/counter.
// (RL10) Software switches off before changing mode; timer mode leaves output unused.
// (RL11) Compare mode on A match: no change, low, high or toggle.
// (RL12) PWM output function: forced inactive, forced active, waveform, undefined.
// (RL13) Compare match requesting the level already present shows no change.
// (RL14) Software changes PWM output function only while switched off.
// (RL15) Initial level bit: start level in compare, active level in PWM, unused in timer.
// (RL16) Invert bit inverts both output pins; ignored in timer mode.
// (RL17) Swap bit: period value sets period and A sets duty, or reversed.
// (RL18) PWM mode ignores the clear source bit.
// (RL19) Compare A split low byte 7..0, high byte 9..8; spare bits read zero.
// (RL20) Low byte write goes to a buffer, committed when the high byte is written.
// (RL21) Compare mode, clear source zero: both A flag and period flag are raised.
// (RL22) PWM duty at or above the period gives full duty.
// (RL23) Running counter increments per count clock event and wraps 1023 to zero.
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/100ps
module compact_timer_control (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Avalon-MM slave
	input wire logic [ctm_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [ctm_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [ctm_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Count clock sources
	input wire logic i_high_clock_tick,
	input wire logic i_sub_clock_tick,
	input wire logic i_external_count_pin,
	// Timer outputs
	output logic o_timer_output_pin_0,
	output logic o_timer_output_pin_1
);
	import ctm_pkg::*;

	// ****************************************
	// State
	// ****************************************
	clock_run_ctrl_t c0_ff, nxt_c0;
	mode_out_ctrl_t c1_ff, nxt_c1;
	event_flags_t flags_ff, nxt_flags;
	logic [9:0] cmp_a_ff, nxt_cmp_a;
	logic [7:0] low_buf_ff, nxt_low_buf;
	logic [7:0] cnt_buf_ff, nxt_cnt_buf;
	logic [9:0] count_ff, nxt_count;
	logic on_prev_ff, nxt_on_prev;
	logic level_ff, nxt_level;
	logic pin_ff, nxt_pin;
	logic wait_ff, nxt_wait;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] sys_div_ff, nxt_sys_div;
	logic [5:0] high_div_ff, nxt_high_div;
	logic ext_prev_ff, nxt_ext_prev;

	// ****************************************
	// Combinational helpers
	// ****************************************
	logic wr_do, rd_do, rd_start, lane0;
	logic on_rise, running, tick;
	logic [10:0] inc11, period11, duty11;
	logic [9:0] cnt_inc;
	logic is_pwm, ovf, a_hit, p_hit, clr, pwm_wave, pwm_level;
	logic per_hit, duty_hit;

	// ****************************************
	// Bus slave
	// ****************************************
	always_comb begin
		// Answer one cycle after the request is seen, so read data is a flop
		rd_start = i_avs_read && wait_ff;
		rd_do = i_avs_read && !wait_ff;
		wr_do = i_avs_write && !wait_ff;
		lane0 = i_avs_byteenable[0];
		nxt_wait = 1'b1;
		if ((i_avs_read || i_avs_write) && wait_ff) begin
			nxt_wait = 1'b0;
		end
		nxt_rdata = rdata_ff;
		if (rd_start) begin
			nxt_rdata = 32'h0000_0000;
			unique case (i_avs_address)
				OFS_CLOCK_RUN_CTRL: nxt_rdata[7:0] = c0_ff;
				OFS_MODE_OUT_CTRL: nxt_rdata[7:0] = c1_ff;
				OFS_CMP_A_LOW: nxt_rdata[7:0] = low_buf_ff;
				OFS_CMP_A_HIGH: nxt_rdata[1:0] = cmp_a_ff[9:8]; // see (RL19)
				OFS_COUNT_LOW: nxt_rdata[7:0] = cnt_buf_ff;
				OFS_COUNT_HIGH: nxt_rdata[1:0] = count_ff[9:8];
				OFS_EVENT_FLAGS: nxt_rdata[1:0] = flags_ff;
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Registers and buffers
	// ****************************************
	always_comb begin
		nxt_c0 = c0_ff;
		nxt_c1 = c1_ff;
		nxt_cmp_a = cmp_a_ff;
		nxt_low_buf = low_buf_ff;
		nxt_cnt_buf = cnt_buf_ff;
		if (wr_do && lane0) begin
			unique case (i_avs_address)
				OFS_CLOCK_RUN_CTRL: nxt_c0 = i_avs_writedata[7:0];
				OFS_MODE_OUT_CTRL: nxt_c1 = i_avs_writedata[7:0];
				OFS_CMP_A_LOW: nxt_low_buf = i_avs_writedata[7:0]; // see (RL20)
				OFS_CMP_A_HIGH: nxt_cmp_a = {i_avs_writedata[1:0], low_buf_ff}; // see (RL20)
				default: nxt_c0 = c0_ff;
			endcase
		end
		// High-byte reads latch the low byte one cycle after the high bits are sampled, for the following low read
		if (rd_do && i_avs_address == OFS_CMP_A_HIGH) begin
			nxt_low_buf = cmp_a_ff[7:0];
		end
		if (rd_do && i_avs_address == OFS_COUNT_HIGH) begin
			nxt_cnt_buf = count_ff[7:0];
		end
	end

	// ****************************************
	// Count clock selection
	// ****************************************
	always_comb begin
		nxt_sys_div = sys_div_ff + 2'h1;
		nxt_high_div = high_div_ff;
		if (i_high_clock_tick) begin
			nxt_high_div = high_div_ff + 6'h01;
		end
		nxt_ext_prev = i_external_count_pin;
		unique case (c0_ff.count_clock_select) // see (RL2)
			CK_SYS_DIV4: tick = sys_div_ff == SYS_DIV4_LAST;
			CK_SYS: tick = 1'b1;
			CK_HIGH_DIV16: tick = i_high_clock_tick && high_div_ff[3:0] == HIGH_DIV16_LAST;
			CK_HIGH_DIV64: tick = i_high_clock_tick && high_div_ff == HIGH_DIV64_LAST;
			CK_SUB: tick = i_sub_clock_tick;
			CK_RESERVED: tick = 1'b0; // see (RL3)
			CK_PIN_RISE: tick = i_external_count_pin && !ext_prev_ff;
			CK_PIN_FALL: tick = !i_external_count_pin && ext_prev_ff;
		endcase
	end

	// ****************************************
	// Counter, comparators and flags
	// ****************************************
	always_comb begin
		nxt_on_prev = c0_ff.counter_on;
		on_rise = c0_ff.counter_on && !on_prev_ff;
		running = c0_ff.counter_on && !c0_ff.count_pause && tick; // see (RL1)
		is_pwm = c1_ff.operating_mode_select == MODE_PWM; // see (RL9)
		inc11 = {1'b0, count_ff} + 11'h001;
		cnt_inc = inc11[9:0]; // see (RL23)
		ovf = count_ff == COUNT_MAX;
		// Period compare matches bits 9..7 when bits 6..0 are zero; a zero value stands for overflow
		if (c0_ff.period_match_bits == 3'h0) begin
			p_hit = ovf; // see (RL6)
		end else begin
			p_hit = cnt_inc[9:7] == c0_ff.period_match_bits && cnt_inc[6:0] == 7'h00; // see (RL6)
		end
		a_hit = cmp_a_ff != 10'h000 && cnt_inc == cmp_a_ff;
		// PWM roles, 11 bits so that a full 1024 period compares cleanly
		if (c1_ff.period_duty_swap) begin // see (RL17)
			period11 = (cmp_a_ff == 10'h000) ? FULL_PERIOD : {1'b0, cmp_a_ff};
			duty11 = (c0_ff.period_match_bits == 3'h0) ? FULL_PERIOD :
				{1'b0, c0_ff.period_match_bits, 7'h00};
		end else begin
			period11 = (c0_ff.period_match_bits == 3'h0) ? FULL_PERIOD :
				{1'b0, c0_ff.period_match_bits, 7'h00};
			duty11 = {1'b0, cmp_a_ff};
		end
		per_hit = inc11 == period11;
		duty_hit = inc11 == duty11;
		if (is_pwm) begin
			clr = per_hit; // see (RL18)
		end else if (c1_ff.clear_source_select) begin
			clr = a_hit; // see (RL8)
		end else begin
			clr = p_hit; // see (RL7)
		end
		nxt_count = count_ff;
		if (on_rise) begin
			nxt_count = RST_COUNT; // see (RL4)
		end else if (running) begin
			nxt_count = clr ? RST_COUNT : cnt_inc;
		end
		// Set wins over a clear in the same cycle
		nxt_flags = flags_ff;
		if (wr_do && lane0 && i_avs_address == OFS_EVENT_FLAGS) begin
			nxt_flags = flags_ff & ~event_flags_t'(i_avs_writedata[1:0]);
		end
		if (running && !on_rise) begin
			if (is_pwm) begin
				if (c1_ff.period_duty_swap ? per_hit : duty_hit) begin
					nxt_flags.compare_a_flag = 1'b1;
				end
				if (c1_ff.period_duty_swap ? duty_hit : per_hit) begin
					nxt_flags.period_match_flag = 1'b1;
				end
			end else begin
				if (a_hit) begin
					nxt_flags.compare_a_flag = 1'b1; // see (RL21)
				end
				if (p_hit && !c1_ff.clear_source_select) begin
					nxt_flags.period_match_flag = 1'b1; // see (RL21)
				end
			end
		end
	end

	// ****************************************
	// Output level
	// ****************************************
	always_comb begin
		// Duty at or above period keeps the count below duty all the time
		pwm_wave = {1'b0, count_ff} < duty11; // see (RL22)
		unique case (c1_ff.output_function_select) // see (RL12)
			IO_NONE: pwm_level = !c1_ff.output_initial_level;
			IO_LOW: pwm_level = c1_ff.output_initial_level;
			IO_HIGH: pwm_level = pwm_wave ? c1_ff.output_initial_level :
				!c1_ff.output_initial_level; // see (RL15)
			IO_TOGGLE: pwm_level = !c1_ff.output_initial_level;
		endcase
		nxt_level = level_ff;
		if (is_pwm) begin
			nxt_level = pwm_level;
		end else if (c1_ff.operating_mode_select == MODE_COMPARE) begin
			if (on_rise) begin
				nxt_level = c1_ff.output_initial_level; // see (RL5)
			end else if (running && a_hit) begin
				unique case (c1_ff.output_function_select) // see (RL11)
					IO_NONE: nxt_level = level_ff;
					IO_LOW: nxt_level = 1'b0; // see (RL13)
					IO_HIGH: nxt_level = 1'b1; // see (RL13)
					IO_TOGGLE: nxt_level = !level_ff;
				endcase
			end
		end
		// Timer mode leaves the pin unused and ignores inversion
		if (c1_ff.operating_mode_select == MODE_TIMER ||
			c1_ff.operating_mode_select == MODE_UNDEF) begin
			nxt_pin = 1'b0; // see (RL10)
		end else begin
			nxt_pin = level_ff ^ c1_ff.output_invert; // see (RL16)
		end
	end

	// ****************************************
	// Flip-flops
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			c0_ff <= RST_CLOCK_RUN_CTRL;
			c1_ff <= RST_MODE_OUT_CTRL;
			flags_ff <= 2'h0;
			cmp_a_ff <= RST_CMP_A;
			low_buf_ff <= 8'h00;
			cnt_buf_ff <= 8'h00;
			count_ff <= RST_COUNT;
			on_prev_ff <= 1'b0;
			level_ff <= 1'b0;
			pin_ff <= 1'b0;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
			sys_div_ff <= 2'h0;
			high_div_ff <= 6'h00;
			ext_prev_ff <= 1'b0;
		end else begin
			c0_ff <= nxt_c0;
			c1_ff <= nxt_c1;
			flags_ff <= nxt_flags;
			cmp_a_ff <= nxt_cmp_a;
			low_buf_ff <= nxt_low_buf;
			cnt_buf_ff <= nxt_cnt_buf;
			count_ff <= nxt_count;
			on_prev_ff <= nxt_on_prev;
			level_ff <= nxt_level;
			pin_ff <= nxt_pin;
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			sys_div_ff <= nxt_sys_div;
			high_div_ff <= nxt_high_div;
			ext_prev_ff <= nxt_ext_prev;
		end
	end

	// Both pins carry the same signal; any pin-side inverse is outside this block
	assign o_timer_output_pin_0 = pin_ff;
	assign o_timer_output_pin_1 = pin_ff;
	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;

	// ****************************************
	// Assertions
	// ****************************************
	AST_PAUSE_HOLDS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL1)
		(c0_ff.count_pause && on_prev_ff && c0_ff.counter_on) |=> count_ff == $past(count_ff))
		else $error("Counter moved while paused");
	AST_RESERVED_STILL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL3)
		(c0_ff.count_clock_select == CK_RESERVED && !on_rise) |=> $stable(count_ff))
		else $error("Counter moved with reserved clock");
	AST_SYS_ADVANCE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL2)
		(c0_ff.count_clock_select == CK_SYS && c0_ff.counter_on && on_prev_ff &&
		!c0_ff.count_pause && !clr) |=> count_ff == $past(count_ff) + 10'h001)
		else $error("Counter did not advance on system clock");
	AST_ON_RISE_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL4)
		$rose(c0_ff.counter_on) |=> count_ff == RST_COUNT)
		else $error("Counter not cleared on switch on");
	AST_OFF_HOLDS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL4)
		(!c0_ff.counter_on) [*2] |-> $stable(count_ff))
		else $error("Counter moved while off");
	AST_INIT_LEVEL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL5)
		(on_rise && c1_ff.operating_mode_select == MODE_COMPARE && $stable(c1_ff))
		|=> level_ff == $past(c1_ff.output_initial_level))
		else $error("Output not at initial level after switch on");
	AST_A_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL8)
		(running && !on_rise && !is_pwm && c1_ff.clear_source_select && a_hit)
		|=> count_ff == RST_COUNT ##0 flags_ff.compare_a_flag)
		else $error("Compare A match did not clear counter");
	AST_P_FLAG: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL21)
		(running && !on_rise && !is_pwm && !c1_ff.clear_source_select && p_hit)
		|=> flags_ff.period_match_flag && count_ff == RST_COUNT)
		else $error("Period match did not clear and flag");
	AST_FULL_DUTY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL22)
		(is_pwm && c1_ff.output_function_select == IO_HIGH && duty11 >= period11 &&
		$stable(c1_ff) && $stable(c0_ff)) |=> level_ff == $past(c1_ff.output_initial_level))
		else $error("Full duty not held");
	AST_HIGH_READ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL19)
		(rd_start && i_avs_address == OFS_CMP_A_HIGH) |=> o_avs_readdata[31:2] == 30'h0
		&& !o_avs_waitrequest)
		else $error("High byte spare bits not zero");
	// Pins lag the internal level by one edge, so pin checks look one edge ahead
	AST_TIMER_PIN_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL15)
		(c1_ff.operating_mode_select == MODE_TIMER)
		|=> !o_timer_output_pin_0 && !o_timer_output_pin_1)
		else $error("Output pin driven in timer mode");
	AST_UNDEF_PIN_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL9)
		(c1_ff.operating_mode_select == MODE_UNDEF)
		|=> !o_timer_output_pin_0 && !o_timer_output_pin_1)
		else $error("Output pin driven in undefined mode");
	AST_PWM_NO_A_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL18)
		(running && !on_rise && is_pwm && !per_hit) |=> count_ff == $past(cnt_inc))
		else $error("PWM counter cleared outside a period match");
	AST_A_FLAG_SET: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see (RL21)
		(running && !on_rise && !is_pwm && !c1_ff.clear_source_select && a_hit)
		|=> flags_ff.compare_a_flag)
		else $error("Compare A flag not raised with period clearing");
	COV_CMP_TOGGLE: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		running && a_hit && c1_ff.output_function_select == IO_TOGGLE);
	COV_PWM_PERIOD: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		running && is_pwm && per_hit);
	COV_OVERFLOW: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		running && ovf);
	COV_PIN_EDGE: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		running && c0_ff.count_clock_select == CK_PIN_FALL);
	COV_FULL_DUTY: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		running && is_pwm && duty11 >= period11);

endmodule : compact_timer_control

// File: compact_timer_control_tb_top.sv
// Purpose: Self-checking bench for the compact 10-bit timer control block
// Assumes: Avalon-MM answers in one cycle; pin edges and ticks are synchronous
// Notes: Integer model of counter, compare level and compare A value is compared at register reads and pin samples
`timescale 1ns/100ps
module compact_timer_control_tb_top;
	import ctm_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

	// ****************************************
	// Signals and model state
	// ****************************************
	logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic high_tick, sub_tick, count_pin, pin_0, pin_1, m_lvl;
	logic [15:0] lfsr;
	clock_run_ctrl_t m_c0;
	mode_out_ctrl_t m_c1;
	int miscompares, checked, cycles, m_cnt, m_cmpa, k, hi, n;
	int pd[3] = '{0, 0, 1};
	int ca[3] = '{32, 200, 256};
	int pp[3] = '{128, 128, 256};
	int du[3] = '{32, 128, 128};

	compact_timer_control u_compact_timer_control (
		.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest), .i_high_clock_tick(high_tick),
		.i_sub_clock_tick(sub_tick), .i_external_count_pin(count_pin),
		.o_timer_output_pin_0(pin_0), .o_timer_output_pin_1(pin_1));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Cuts a hung run short; ceiling is several times the expected length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd

	task automatic wrap_up();
		$display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// Request held until waitrequest is sampled low, then released
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		if (!w)
			`CHK(avs_readdata[31:8], 24'h00_0000)
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask : rd_chk

	task automatic set_c0(input logic pau, input logic [2:0] ck, input logic on,
		input logic [2:0] rp);
		if (on && !m_c0.counter_on) begin
			m_cnt = 0;
			m_lvl = m_c1.output_initial_level;
		end
		m_c0 = {pau, ck, on, rp};
		wr(OFS_CLOCK_RUN_CTRL, m_c0);
	endtask : set_c0

	// Mode and output changes are made only while switched off
	task automatic set_c1(input logic [1:0] md, input logic [1:0] io, input logic oc,
		input logic pol, input logic dpx, input logic cclr);
		set_c0(1'b0, m_c0.count_clock_select, 1'b0, m_c0.period_match_bits);
		m_c1 = {md, io, oc, pol, dpx, cclr};
		wr(OFS_MODE_OUT_CTRL, m_c1);
		rd_chk(OFS_MODE_OUT_CTRL, m_c1);
	endtask : set_c1

	task automatic set_a(input logic [9:0] v);
		wr(OFS_CMP_A_LOW, v[7:0]);
		wr(OFS_CMP_A_HIGH, {6'h00, v[9:8]});
		m_cmpa = v;
	endtask : set_a

	task automatic chk_cnt();
		logic [7:0] h, l;
		bus(1'b0, OFS_COUNT_HIGH, 8'h00, h);
		bus(1'b0, OFS_COUNT_LOW, 8'h00, l);
		`CHK({h[1:0], l}, 10'(m_cnt))
		`CHK(h[7:2], 6'h00)
	endtask : chk_cnt

	task automatic chk_pin(input logic e);
		repeat (3) @(posedge clk_sys);
		`CHK(pin_0, e)
		`CHK(pin_1, e)
	endtask : chk_pin

	// One count event in compare or timer mode
	task automatic step();
		m_cnt = (m_cnt + 1) % 1024;
		if (m_cmpa != 0 && m_cnt == m_cmpa) begin
			case (m_c1.output_function_select)
				IO_LOW: m_lvl = 1'b0;
				IO_HIGH: m_lvl = 1'b1;
				IO_TOGGLE: m_lvl = ~m_lvl;
				default: ;
			endcase
			if (m_c1.clear_source_select)
				m_cnt = 0;
		end
		if (!m_c1.clear_source_select && m_c0.period_match_bits != 3'h0
			&& m_cnt == 128 * m_c0.period_match_bits)
			m_cnt = 0;
	endtask : step

	task automatic edges(input int e);
		for (int i = 0; i < e; i++) begin
			@(posedge clk_sys);
			count_pin <= 1'b1;
			@(posedge clk_sys);
			count_pin <= 1'b0;
			if (m_c0.counter_on && !m_c0.count_pause && m_c0.count_clock_select >= CK_PIN_RISE)
				step();
		end
		repeat (2) @(posedge clk_sys);
	endtask : edges

	task automatic ticks(input logic sub, input int e, input int div);
		for (int i = 0; i < e; i++) begin
			@(posedge clk_sys);
			sub_tick <= sub;
			high_tick <= !sub;
			@(posedge clk_sys);
			sub_tick <= 1'b0;
			high_tick <= 1'b0;
		end
		m_cnt = (m_cnt + e / div) % 1024;
	endtask : ticks

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst_b, avs_read, avs_write, high_tick, sub_tick, count_pin} = 6'h00;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h1;
		lfsr = 16'h0018;
		m_c0 = RST_CLOCK_RUN_CTRL;
		m_c1 = RST_MODE_OUT_CTRL;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd_chk(OFS_CLOCK_RUN_CTRL, RST_CLOCK_RUN_CTRL);
		rd_chk(OFS_MODE_OUT_CTRL, RST_MODE_OUT_CTRL);
		rd_chk(OFS_CMP_A_HIGH, 8'h00);
		rd_chk(OFS_CMP_A_LOW, 8'h00);
		wr(8'h40, 8'hFF);
		rd_chk(8'h40, 8'h00);
		$display("Test reset and unmapped done");
		for (k = 0; k < 4; k++) begin
			set_a(10'({rnd(), rnd()}));
			rd_chk(OFS_CMP_A_HIGH, {6'h00, 2'(m_cmpa >> 8)});
			rd_chk(OFS_CMP_A_LOW, 8'(m_cmpa));
		end
		wr(OFS_CMP_A_LOW, ~8'(m_cmpa));
		rd_chk(OFS_CMP_A_HIGH, {6'h00, 2'(m_cmpa >> 8)});
		rd_chk(OFS_CMP_A_LOW, 8'(m_cmpa));
		$display("Test compare A pairing done");
		set_c1(MODE_COMPARE, IO_NONE, 1'b0, 1'b0, 1'b0, 1'b0);
		set_c0(1'b0, CK_PIN_RISE, 1'b1, 3'h0);
		edges(rnd() % 40 + 5);
		chk_cnt();
		set_c0(1'b0, CK_PIN_FALL, 1'b1, 3'h0);
		edges(7);
		chk_cnt();
		set_c0(1'b0, CK_RESERVED, 1'b1, 3'h0);
		edges(5);
		chk_cnt();
		set_c0(1'b1, CK_PIN_RISE, 1'b1, 3'h0);
		edges(5);
		chk_cnt();
		set_c0(1'b0, CK_PIN_RISE, 1'b1, 3'h0);
		edges(3);
		chk_cnt();
		set_c0(1'b0, CK_PIN_RISE, 1'b0, 3'h0);
		edges(4);
		chk_cnt();
		set_c0(1'b0, CK_PIN_RISE, 1'b1, 3'h0);
		chk_cnt();
		$display("Test pin clock, pause and on/off done");
		set_c0(1'b0, CK_SUB, 1'b1, 3'h0);
		ticks(1'b1, 9, 1);
		chk_cnt();
		set_c0(1'b0, CK_HIGH_DIV16, 1'b1, 3'h0);
		ticks(1'b0, 48, 16);
		chk_cnt();
		set_c0(1'b1, CK_HIGH_DIV64, 1'b1, 3'h0);
		set_c0(1'b0, CK_HIGH_DIV64, 1'b1, 3'h0);
		ticks(1'b0, 128, 64);
		chk_cnt();
		// Run window between two effective writes is 397 waits plus 3 bus cycles
		set_c0(1'b1, CK_SYS_DIV4, 1'b1, 3'h0);
		set_c0(1'b0, CK_SYS_DIV4, 1'b1, 3'h0);
		repeat (397) @(posedge clk_sys);
		set_c0(1'b1, CK_SYS_DIV4, 1'b1, 3'h0);
		m_cnt = m_cnt + 100;
		chk_cnt();
		$display("Test internal clock sources done");
		for (k = 0; k < 6; k++) begin
			set_c1(MODE_COMPARE, 2'(1 + k / 2), 1'(k), 1'(k / 2), 1'b0, 1'b1);
			set_a(10'h003);
			set_c0(1'b0, CK_PIN_RISE, 1'b1, 3'h0);
			chk_pin(m_lvl ^ m_c1.output_invert);
			edges(3);
			chk_pin(m_lvl ^ m_c1.output_invert);
			chk_cnt();
			edges(3);
			chk_pin(m_lvl ^ m_c1.output_invert);
		end
		$display("Test compare output done");
		set_c1(MODE_COMPARE, IO_NONE, 1'b0, 1'b0, 1'b0, 1'b0);
		set_a(10'h005);
		wr(OFS_EVENT_FLAGS, 8'h03);
		set_c0(1'b0, CK_PIN_RISE, 1'b1, 3'h1);
		edges(127);
		chk_cnt();
		edges(1);
		chk_cnt();
		rd_chk(OFS_EVENT_FLAGS, 8'h03);
		wr(OFS_EVENT_FLAGS, 8'h03);
		rd_chk(OFS_EVENT_FLAGS, 8'h00);
		set_c0(1'b0, CK_PIN_RISE, 1'b0, 3'h0);
		set_c0(1'b0, CK_PIN_RISE, 1'b1, 3'h0);
		edges(1023);
		chk_cnt();
		edges(1);
		chk_cnt();
		$display("Test period and overflow done");
		for (k = 0; k < 3; k++) begin
			set_c1(MODE_PWM, 2'h2, 1'b1, 1'(k == 0), 1'(pd[k]), 1'b1);
			set_a(10'(ca[k]));
			set_c0(1'b0, CK_SYS, 1'b1, 3'h1);
			repeat (300) @(posedge clk_sys);
			hi = 0;
			repeat (pp[k]) begin
				@(posedge clk_sys);
				if (pin_0 === 1'b1)
					hi++;
			end
			n = (k == 0) ? pp[k] - du[k] : du[k];
			`CHK(hi, n)
		end
		set_c1(MODE_PWM, IO_NONE, 1'b1, 1'b1, 1'b0, 1'b0);
		set_c0(1'b0, CK_SYS, 1'b1, 3'h1);
		chk_pin(1'b1);
		set_c1(MODE_PWM, IO_LOW, 1'b1, 1'b1, 1'b0, 1'b0);
		set_c0(1'b0, CK_SYS, 1'b1, 3'h1);
		chk_pin(1'b0);
		$display("Test PWM done");
		set_c1(MODE_TIMER, IO_NONE, 1'b1, 1'b1, 1'b0, 1'b0);
		set_c0(1'b0, CK_PIN_RISE, 1'b1, 3'h0);
		chk_pin(1'b0);
		edges(4);
		chk_cnt();
		set_c1(MODE_UNDEF, IO_NONE, 1'b1, 1'b1, 1'b0, 1'b0);
		chk_pin(1'b0);
		$display("Test timer mode done");
		wrap_up();
	end

endmodule : compact_timer_control_tb_top

// File: ctm_pkg.sv
// Purpose: Shared constants and field layouts for the compact 10-bit timer control block
// Assumes: Registers sit one per 32-bit Avalon-MM word, data in the low byte
// Notes: Offsets are byte addresses; field positions and the control, compare A and count reset values live here
package ctm_pkg;

	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CLOCK_RUN_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE_OUT_CTRL = 8'h04;
	localparam logic [7:0] OFS_CMP_A_LOW = 8'h08;
	localparam logic [7:0] OFS_CMP_A_HIGH = 8'h0C;
	localparam logic [7:0] OFS_COUNT_LOW = 8'h10;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h14;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h18;

	// ****************************************
	// Field layouts
	// ****************************************
	typedef struct packed {
		logic count_pause;
		logic [2:0] count_clock_select;
		logic counter_on;
		logic [2:0] period_match_bits;
	} clock_run_ctrl_t;

	typedef struct packed {
		logic [1:0] operating_mode_select;
		logic [1:0] output_function_select;
		logic output_initial_level;
		logic output_invert;
		logic period_duty_swap;
		logic clear_source_select;
	} mode_out_ctrl_t;

	typedef struct packed {
		logic period_match_flag;
		logic compare_a_flag;
	} event_flags_t;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_CLOCK_RUN_CTRL = 8'h00;
	localparam logic [7:0] RST_MODE_OUT_CTRL = 8'h00;
	localparam logic [9:0] RST_CMP_A = 10'h000;
	localparam logic [9:0] RST_COUNT = 10'h000;

	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_HIGH_DIV16 = 3'h2;
	localparam logic [2:0] CK_HIGH_DIV64 = 3'h3;
	localparam logic [2:0] CK_SUB = 3'h4;
	localparam logic [2:0] CK_RESERVED = 3'h5;
	localparam logic [2:0] CK_PIN_RISE = 3'h6;
	localparam logic [2:0] CK_PIN_FALL = 3'h7;

	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_UNDEF = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;

	localparam logic [1:0] IO_NONE = 2'h0;
	localparam logic [1:0] IO_LOW = 2'h1;
	localparam logic [1:0] IO_HIGH = 2'h2;
	localparam logic [1:0] IO_TOGGLE = 2'h3;

	// ****************************************
	// Counts
	// ****************************************
	localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
	localparam logic [3:0] HIGH_DIV16_LAST = 4'hF;
	localparam logic [5:0] HIGH_DIV64_LAST = 6'h3F;
	localparam logic [9:0] COUNT_MAX = 10'h3FF;
	localparam logic [10:0] FULL_PERIOD = 11'h400;

endpackage : ctm_pkg
